// ### hdl/dram_host_ctrl.sv
// host-side controller that drives an asynchronous dram through its strobes
`timescale 1ns/1ps

// Contract
// - row strobe opens every read, write and row-only refresh and stays low its minimum time.
// - write enable is settled before the column strobe falls and held.
// - row then column address share the same address pins.
// - read: row address set up, row strobe falls, held low long enough.
// - read: column address out, write enable high, column strobe falls, held.
// - every read or write ends with both strobes back high.
// - write: row address, column address, write enable low before column strobe.
// - write data is driven before the column strobe falls.
// - every row is refreshed within the refresh period.
// - refresh one row at a time, spread over the refresh period.
// - row-only refresh: row address, row strobe low, column high, then row up.
// - column-first: column low, write enable high, row low, column up, row up.
// - in column-first refresh the column strobe stays low its minimum time.
// - column strobe stays high its minimum time between assertions.
// - sleep refresh: column-first start, row strobe held low throughout sleep.
module dram_host_ctrl #(
	parameter int ROW_BITS             = 9,
	parameter int COL_BITS             = 9,
	parameter int DATA_BITS            = 8,
	parameter int REFRESH_INTERVAL_CYC = dram_host_pkg::REFRESH_INTERVAL_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         reqValid,
	output logic                              reqReady,
	input  wire logic                         reqWrite,
	input  wire logic [ROW_BITS+COL_BITS-1:0] reqAddr,
	input  wire logic [DATA_BITS-1:0]         reqWdata,
	output logic                              rspValid,
	output logic [DATA_BITS-1:0]              rspRdata,
	input  wire logic                         refreshMode,
	input  wire logic                         sleepReq,
	output logic                              sleepActive,
	output logic                              rasN,
	output logic                              casN,
	output logic                              weN,
	output logic                              oeN,
	output logic [ROW_BITS-1:0]               addrOut,
	output logic [DATA_BITS-1:0]              dqOut,
	output logic                              dqOeN,
	input  wire logic [DATA_BITS-1:0]         dqIn
);

	generate
		if (ROW_BITS < 1 || COL_BITS < 1 || COL_BITS > ROW_BITS || DATA_BITS < 1) begin : g_bad
			$error("dram_host_ctrl: need 1 <= COL_BITS <= ROW_BITS and DATA_BITS >= 1");
		end
	endgenerate

	typedef struct packed {
		dram_host_pkg::ctrl_state_t st;
		logic [15:0]                cnt;
		logic [15:0]                rasAge;
		logic                       isWrite;
		logic                       isRef;
		logic                       sleepMode;
		logic [COL_BITS-1:0]        col;
		logic [DATA_BITS-1:0]       wdata;
		logic                       refPend;
		logic [ROW_BITS-1:0]        refRow;
		logic                       sleepAct;
		logic                       rasN;
		logic                       casN;
		logic                       weN;
		logic                       oeN;
		logic                       dqOeN;
		logic [ROW_BITS-1:0]        addr;
		logic [DATA_BITS-1:0]       dqOut;
		logic                       rspValid;
		logic [DATA_BITS-1:0]       rspData;
		logic [DATA_BITS-1:0]       sync1;
		logic [DATA_BITS-1:0]       sync2;
		logic [DATA_BITS-1:0]       sync3;
	} ctrl_t;

	ctrl_t s_q;
	ctrl_t s_d;
	logic  refTick;

	// wait counter load so a state lasts exactly c cycles
	function automatic logic [15:0] ld(input logic [15:0] c);
		return c - 16'h0001;
	endfunction

	refresh_timer #(
		.INTERVAL_CYC (REFRESH_INTERVAL_CYC)
	) u_refresh_timer (
		.clk   (clk),
		.reset (reset),
		.tick  (refTick)
	);

	// new work only from idle, and never ahead of pending refresh or sleep
	assign reqReady = (s_q.st == dram_host_pkg::ST_IDLE) && !s_q.refPend && !sleepReq;

	always_comb begin
		s_d          = s_q;
		s_d.rspValid = 1'b0;
		// three-stage input sync; only stages two and three are compared
		s_d.sync1 = dqIn;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		if (s_q.cnt != 16'h0000) begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
		// row strobe low time, saturating
		if (!s_q.rasN && s_q.rasAge != 16'hffff) begin
			s_d.rasAge = s_q.rasAge + 16'h0001;
		end
		unique case (s_q.st)
			dram_host_pkg::ST_IDLE: begin
				if (sleepReq) begin
					s_d.sleepMode = 1'b1;
					s_d.casN      = 1'b0;
					s_d.weN       = 1'b1;
					s_d.st        = dram_host_pkg::ST_CF_CAS;
					s_d.cnt       = ld(dram_host_pkg::T_CSR_CYC);
				end else if (s_q.refPend) begin
					s_d.refPend   = 1'b0;
					s_d.isRef     = 1'b1;
					s_d.sleepMode = 1'b0;
					if (refreshMode == dram_host_pkg::REFRESH_ROW_ONLY) begin
						s_d.addr   = s_q.refRow;
						s_d.refRow = s_q.refRow + ROW_BITS'(1); // walk every row in turn
						s_d.st     = dram_host_pkg::ST_ROW_SET;
						s_d.cnt    = ld(dram_host_pkg::T_ASR_CYC);
					end else begin
						// device picks the row itself, address pins are don't-care
						s_d.casN = 1'b0;
						s_d.weN  = 1'b1;
						s_d.st   = dram_host_pkg::ST_CF_CAS;
						s_d.cnt  = ld(dram_host_pkg::T_CSR_CYC);
					end
				end else if (reqValid) begin
					s_d.isRef   = 1'b0;
					s_d.isWrite = reqWrite;
					s_d.col     = reqAddr[COL_BITS-1:0];
					s_d.wdata   = reqWdata;
					s_d.addr    = reqAddr[ROW_BITS+COL_BITS-1:COL_BITS]; // row first
					s_d.st      = dram_host_pkg::ST_ROW_SET;
					s_d.cnt     = ld(dram_host_pkg::T_ASR_CYC);
				end
			end
			dram_host_pkg::ST_ROW_SET: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.rasN   = 1'b0; // row strobe opens the cycle
					s_d.rasAge = 16'h0000;
					s_d.st     = dram_host_pkg::ST_RAS_LOW;
					s_d.cnt    = ld(s_q.isRef ? dram_host_pkg::T_RAS_CYC
					                          : dram_host_pkg::T_RCD_CYC);
				end
			end
			dram_host_pkg::ST_RAS_LOW: begin
				if (s_q.cnt == 16'h0000) begin
					if (s_q.isRef) begin
						// row-only refresh done: column strobe never fell
						s_d.rasN = 1'b1;
						s_d.st   = dram_host_pkg::ST_RELEASE;
						s_d.cnt  = ld(dram_host_pkg::T_PRE_CYC);
					end else begin
						s_d.addr = ROW_BITS'(s_q.col);
						s_d.weN  = !s_q.isWrite; // set up ahead of the column edge
						if (s_q.isWrite) begin
							s_d.dqOut = s_q.wdata;
							s_d.dqOeN = 1'b0;
						end
						s_d.st  = dram_host_pkg::ST_COL_SET;
						s_d.cnt = ld(dram_host_pkg::T_ASC_CYC);
					end
				end
			end
			dram_host_pkg::ST_COL_SET: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.casN = 1'b0;
					s_d.oeN  = s_q.isWrite; // device output only for reads
					s_d.st   = dram_host_pkg::ST_CAS_LOW;
					s_d.cnt  = ld(s_q.isWrite ? dram_host_pkg::T_CAS_CYC
					                          : dram_host_pkg::RD_WAIT_CYC);
				end
			end
			dram_host_pkg::ST_CAS_LOW: begin
				// we and data stay put until the strobes rise, covering hold
				if (s_q.cnt == 16'h0000 && s_q.rasAge >= dram_host_pkg::T_RAS_CYC) begin
					if (s_q.isWrite) begin
						s_d.st = dram_host_pkg::ST_RELEASE;
					end else begin
						s_d.st = dram_host_pkg::ST_RD_CAP;
					end
				end
			end
			dram_host_pkg::ST_RD_CAP: begin
				// take the bus only once two synchronised samples agree
				if (s_q.sync2 == s_q.sync3) begin
					s_d.rspData  = s_q.sync3;
					s_d.rspValid = 1'b1;
					s_d.st       = dram_host_pkg::ST_RELEASE;
				end
			end
			dram_host_pkg::ST_CF_CAS: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.rasN   = 1'b0;
					s_d.rasAge = 16'h0000;
					s_d.st     = dram_host_pkg::ST_CF_RAS;
					s_d.cnt    = ld(dram_host_pkg::T_CHR_CYC);
				end
			end
			dram_host_pkg::ST_CF_RAS: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.casN = 1'b1; // column held low setup plus hold
					s_d.st   = dram_host_pkg::ST_CF_CASUP;
				end
			end
			dram_host_pkg::ST_CF_CASUP: begin
				if (s_q.rasAge >= dram_host_pkg::T_RAS_CYC) begin
					if (s_q.sleepMode) begin
						s_d.sleepAct = 1'b1;
						s_d.st       = dram_host_pkg::ST_SLEEP;
					end else begin
						s_d.st = dram_host_pkg::ST_RELEASE;
					end
				end
			end
			dram_host_pkg::ST_SLEEP: begin
				// row strobe stays low; the device paces its own refresh
				if (!sleepReq) begin
					s_d.sleepAct  = 1'b0;
					s_d.sleepMode = 1'b0;
					s_d.st        = dram_host_pkg::ST_RELEASE;
				end
			end
			dram_host_pkg::ST_RELEASE: begin
				if (s_q.cnt == 16'h0000) begin
					s_d.st = dram_host_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = dram_host_pkg::ST_IDLE;
			end
		endcase
		// closing a cycle: both strobes high, bus released, precharge wait
		if (s_d.st == dram_host_pkg::ST_RELEASE && s_q.st != dram_host_pkg::ST_RELEASE) begin
			s_d.rasN  = 1'b1;
			s_d.casN  = 1'b1;
			s_d.weN   = 1'b1;
			s_d.oeN   = 1'b1;
			s_d.dqOeN = 1'b1;
			s_d.cnt   = ld(dram_host_pkg::T_PRE_CYC);
		end
		// a tick in the same cycle as the take still leaves one pending
		if (refTick) begin
			s_d.refPend = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q       <= '0;
			s_q.st    <= dram_host_pkg::ST_IDLE;
			s_q.rasN  <= 1'b1;
			s_q.casN  <= 1'b1;
			s_q.weN   <= 1'b1;
			s_q.oeN   <= 1'b1;
			s_q.dqOeN <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rspValid    = s_q.rspValid;
	assign rspRdata    = s_q.rspData;
	assign sleepActive = s_q.sleepAct;
	assign rasN        = s_q.rasN;
	assign casN        = s_q.casN;
	assign weN         = s_q.weN;
	assign oeN         = s_q.oeN;
	assign addrOut     = s_q.addr;
	assign dqOut       = s_q.dqOut;
	assign dqOeN       = s_q.dqOeN;

endmodule

// ### pkg/dram_host_pkg.sv
// timing constants and helpers for the asynchronous dram strobe controller
package dram_host_pkg;

	localparam int CLK_PERIOD_NS = 50;

	// cycles needed to cover a minimum time, never less than one
	function automatic logic [15:0] ns2cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return 16'(c);
	endfunction

	// minimum pin-edge spacings in ns (plain defaults, adjust to the part)
	localparam int T_ASR_NS  = 10;  // row address setup before row strobe falls
	localparam int T_RCD_NS  = 40;  // row strobe low before column address goes out
	localparam int T_ASC_NS  = 10;  // column address / we / data setup before column strobe
	localparam int T_CAS_NS  = 30;  // column strobe low time
	localparam int T_CAC_NS  = 30;  // access delay from column strobe to data
	localparam int T_RAS_NS  = 100; // row strobe low time
	localparam int T_RP_NS   = 60;  // row strobe high time
	localparam int T_CPN_NS  = 20;  // column strobe high time
	localparam int T_CSR_NS  = 10;  // column strobe low before row strobe in refresh
	localparam int T_CHR_NS  = 30;  // column strobe hold after row strobe in refresh

	localparam logic [15:0] T_ASR_CYC = ns2cyc(T_ASR_NS);
	localparam logic [15:0] T_RCD_CYC = ns2cyc(T_RCD_NS);
	localparam logic [15:0] T_ASC_CYC = ns2cyc(T_ASC_NS);
	localparam logic [15:0] T_CAS_CYC = ns2cyc(T_CAS_NS);
	localparam logic [15:0] T_RAS_CYC = ns2cyc(T_RAS_NS);
	localparam logic [15:0] T_CSR_CYC = ns2cyc(T_CSR_NS);
	localparam logic [15:0] T_CHR_CYC = ns2cyc(T_CHR_NS);
	// in reads and writes the strobes rise together, so the precharge wait covers the longer of the two
	localparam logic [15:0] T_PRE_CYC = ns2cyc((T_RP_NS > T_CPN_NS) ? T_RP_NS : T_CPN_NS);

	// read data needs the access delay plus the input synchroniser depth
	localparam int          SYNC_STAGES = 3;
	localparam logic [15:0] RD_WAIT_CYC = ns2cyc(T_CAC_NS) + 16'(SYNC_STAGES);

	// refresh period and row count give the spacing of single-row refreshes
	localparam int REFRESH_PERIOD_NS    = 64000000;
	localparam int REFRESH_ROWS         = 512;
	localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_NS / REFRESH_ROWS / CLK_PERIOD_NS;

	// refresh scheme selected at the refreshMode port
	localparam logic REFRESH_ROW_ONLY     = 1'b0;
	localparam logic REFRESH_COLUMN_FIRST = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ROW_SET   = 4'h1,
		ST_RAS_LOW   = 4'h2,
		ST_COL_SET   = 4'h3,
		ST_CAS_LOW   = 4'h4,
		ST_RD_CAP    = 4'h5,
		ST_CF_CAS    = 4'h6,
		ST_CF_RAS    = 4'h7,
		ST_CF_CASUP  = 4'h8,
		ST_SLEEP     = 4'h9,
		ST_RELEASE   = 4'ha
	} ctrl_state_t;

endpackage

// ### hdl/refresh_timer.sv
// periodic tick that paces single-row refresh cycles
`timescale 1ns/1ps

module refresh_timer #(
	parameter int INTERVAL_CYC = dram_host_pkg::REFRESH_INTERVAL_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	output logic      tick
);

	generate
		if (INTERVAL_CYC < 2 || INTERVAL_CYC > 65535) begin : g_bad_interval
			$error("refresh_timer: INTERVAL_CYC out of range 2..65535");
		end
	endgenerate

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} timer_state_t;

	timer_state_t s_q;
	timer_state_t s_d;

	// count down and pulse once per interval
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == 16'h0000) begin
			s_d.cnt  = 16'(INTERVAL_CYC - 1);
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q     <= '0;
			s_q.cnt <= 16'(INTERVAL_CYC - 1);
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

// ### testbench/dram_host_ctrl_sva.sv
// pin-level checks for the dram strobe controller
`timescale 1ns/1ps
module dram_host_ctrl_sva #(
	parameter int ROW_BITS  = 9,
	parameter int DATA_BITS = 8
) (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 reqReady,
	input wire logic                 sleepReq,
	input wire logic                 sleepActive,
	input wire logic                 rspValid,
	input wire logic                 rasN,
	input wire logic                 casN,
	input wire logic                 weN,
	input wire logic                 oeN,
	input wire logic                 dqOeN,
	input wire logic [DATA_BITS-1:0] dqOut,
	input wire logic [ROW_BITS-1:0]  addrOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// reset itself must leave every strobe idle, so no disable here
	idle_reset_a: assert property (disable iff (1'b0)
		reset |=> rasN && casN && weN && oeN && dqOeN) else $error("strobes busy after reset");
	ras_min_a: assert property ($fell(rasN) |-> !rasN[*2])
		else $error("row strobe low too short");
	ras_pre_a: assert property ($rose(rasN) |-> rasN[*2])
		else $error("precharge too short");
	both_up_a: assert property ($rose(rasN) |-> casN)
		else $error("row strobe rose with column low");
	we_hold_a: assert property (!casN && !$past(casN) |-> $stable(weN))
		else $error("write enable moved under column strobe");
	col_addr_a: assert property ($fell(casN) && !rasN |-> $stable(addrOut))
		else $error("column address not set up");
	wdata_setup_a: assert property ($fell(casN) && !weN |-> !dqOeN && $stable(dqOut))
		else $error("write data not set up");
	oe_read_a: assert property (!oeN |-> weN && dqOeN)
		else $error("output enable in a write");
	colfirst_we_a: assert property ($fell(casN) && rasN |-> weN)
		else $error("column-first start with write enable low");
	// a held sleep request must reach the sleep state once the current cycle drains
	sleep_enter_a: assert property ($rose(sleepReq) |-> ##[1:30] (sleepActive || !sleepReq))
		else $error("sleep not entered in time");
	sleep_hold_a: assert property (sleepActive |-> !rasN && casN)
		else $error("sleep without row strobe held");
	sleep_refuse_a: assert property (sleepReq |-> !reqReady)
		else $error("request accepted during sleep");
	rd_oe_a: assert property (rspValid |-> $past(oeN) == 1'b0)
		else $error("read data without output enable");
	cover property ($fell(casN) && !weN);
	cover property ($fell(casN) && rasN);
	cover property ($rose(sleepActive));
	cover property (rspValid);
endmodule

// ### testbench/dram_cell_model.sv
// behavioural asynchronous dram answering the controller pins
`timescale 1ns/1ps
module dram_cell_model #(
	parameter int ROW_BITS  = 4,
	parameter int COL_BITS  = 4,
	parameter int DATA_BITS = 8
) (
	input  wire logic                 rasN,
	input  wire logic                 casN,
	input  wire logic                 weN,
	input  wire logic                 oeN,
	input  wire logic [ROW_BITS-1:0]  addrOut,
	input  wire logic [DATA_BITS-1:0] dqOut,
	input  wire logic                 dqOeN,
	output logic [DATA_BITS-1:0]      dqIn,
	output int                        rowOnlyCount,
	output int                        colFirstCount,
	output int                        badWrite
);
	logic [DATA_BITS-1:0] mem [2**(ROW_BITS+COL_BITS)];
	logic [ROW_BITS-1:0]  row;
	logic [COL_BITS-1:0]  col;
	logic                 readCyc;
	logic                 casSeen;
	initial begin
		rowOnlyCount = 0;
		colFirstCount = 0;
		badWrite = 0;
		dqIn = '0;
		readCyc = 0;
		// the unknown-to-high step of the row strobe at reset is no refresh
		casSeen = 1;
	end
	// falling row strobe latches the row, or with column low starts an internal refresh
	always @(negedge rasN) begin
		if (casN) begin
			row = addrOut;
		end else begin
			colFirstCount++;
			if (!weN) badWrite++;
		end
	end
	// a row cycle with no column strobe at all is a row-only refresh
	always @(posedge rasN) begin
		if (!casSeen) rowOnlyCount++;
		casSeen = 0;
	end
	always @(negedge casN) begin
		casSeen = 1;
		if (!rasN) begin
			col = addrOut[COL_BITS-1:0];
			readCyc = weN;
			if (!weN) begin
				if (dqOeN) badWrite++;
				mem[{row, col}] = dqOut;
			end
		end
	end
	// released bus toggles so a stale value can never pass for data
	always @(rasN or casN or oeN) #1 begin
		if (!rasN && !casN && !oeN && readCyc) dqIn <= #30 mem[{row, col}];
		else dqIn <= #1 ~dqIn;
	end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the dram strobe controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	localparam int RB = 4;
	localparam int CB = 4;
	localparam int DB = 8;
	logic          clk, reset, reqValid, reqReady, reqWrite, rspValid;
	logic          refreshMode, sleepReq, sleepActive, rasN, casN, weN, oeN, dqOeN;
	logic [RB+CB-1:0] reqAddr;
	logic [RB-1:0] addrOut;
	logic [DB-1:0] reqWdata, rspRdata, dqOut, dqIn;
	int            rowOnlyCount, colFirstCount, badWrite, failures, cmpCount;
	dram_host_ctrl #(.ROW_BITS(RB), .COL_BITS(CB), .DATA_BITS(DB), .REFRESH_INTERVAL_CYC(40))
	i_dram_host_ctrl (.clk, .reset, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata,
		.rspValid, .rspRdata, .refreshMode, .sleepReq, .sleepActive, .rasN, .casN, .weN,
		.oeN, .addrOut, .dqOut, .dqOeN, .dqIn);
	dram_cell_model #(.ROW_BITS(RB), .COL_BITS(CB), .DATA_BITS(DB)) i_dram_cell_model (
		.rasN, .casN, .weN, .oeN, .addrOut, .dqOut, .dqOeN, .dqIn, .rowOnlyCount, .colFirstCount,
		.badWrite);
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait at falling edges; running out ends the run
	task automatic wait_for(ref logic sig, input logic val, input int n);
		for (int i = 0; i < n && sig !== val; i++) @(negedge clk);
		if (sig !== val) begin
			`CHK("wait", val, sig)
			wrap_up();
		end
	endtask
	task automatic access(input logic wr, input logic [RB+CB-1:0] a, input logic [DB-1:0] d,
		output logic [DB-1:0] q);
		reqValid = 1;
		reqWrite = wr;
		reqAddr = a;
		reqWdata = d;
		#1;
		wait_for(reqReady, 1'b1, 200);
		@(negedge clk);
		reqValid = 0;
		q = 'x;
		if (wr) begin
			@(negedge clk);
		end else begin
			wait_for(rspValid, 1'b1, 40);
			q = rspRdata;
		end
	endtask
	task automatic t_reset;
		`CHK("rasN", 1'b1, rasN)
		`CHK("dqOeN", 1'b1, dqOeN)
		`CHK("reqReady", 1'b1, reqReady)
		$display("test reset done");
	endtask
	// back-to-back writes at corner addresses, then read back
	task automatic t_data;
		logic [DB-1:0] q;
		logic [RB+CB-1:0] adr [4] = '{8'h00, 8'hff, 8'h5a, 8'hf0};
		foreach (adr[k]) access(1'b1, adr[k], adr[k] ^ 8'h3c, q);
		foreach (adr[k]) begin
			access(1'b0, adr[k], 8'h00, q);
			`CHK("rspRdata", adr[k] ^ 8'h3c, q)
		end
		`CHK("badWrite", 0, badWrite)
		$display("test data done");
	endtask
	// two and a half refresh intervals of idle, then a read to show the data survived
	task automatic t_refresh(input logic mode);
		int r;
		int c;
		logic [DB-1:0] q;
		r = rowOnlyCount;
		c = colFirstCount;
		refreshMode = mode;
		repeat (100) @(negedge clk);
		`CHK("rowOnlyRefresh", !mode, rowOnlyCount > r)
		`CHK("colFirstRefresh", mode, colFirstCount > c)
		access(1'b0, 8'h5a, 8'h00, q);
		`CHK("rspRdata", 8'h5a ^ 8'h3c, q)
		`CHK("badWrite", 0, badWrite)
		$display("test refresh %0d done", mode);
	endtask
	task automatic t_sleep;
		logic [DB-1:0] q;
		sleepReq = 1;
		wait_for(sleepActive, 1'b1, 30);
		repeat (40) @(negedge clk);
		`CHK("rasN", 1'b0, rasN)
		`CHK("reqReady", 1'b0, reqReady)
		sleepReq = 0;
		access(1'b0, 8'hff, 8'h00, q);
		`CHK("rspRdata", 8'hff ^ 8'h3c, q)
		`CHK("sleepActive", 1'b0, sleepActive)
		$display("test sleep done");
	endtask
	initial begin
		failures = 0;
		cmpCount = 0;
		reset = 1;
		reqValid = 0;
		reqWrite = 0;
		reqAddr = '0;
		reqWdata = '0;
		refreshMode = 0;
		sleepReq = 0;
		repeat (2) @(negedge clk);
		reset = 0;
		@(negedge clk);
		t_reset();
		t_data();
		t_refresh(1'b0);
		t_refresh(1'b1);
		t_sleep();
		wrap_up();
	end
endmodule
bind dram_host_ctrl dram_host_ctrl_sva #(.ROW_BITS(ROW_BITS), .DATA_BITS(DATA_BITS))
	i_dram_host_ctrl_sva (.clk, .reset, .reqReady, .sleepReq, .sleepActive, .rspValid,
	.rasN, .casN, .weN, .oeN, .dqOeN, .dqOut, .addrOut);
